// ===== rtl/stwu_core.sv
`timescale 1ns/1ns
module stwu_core
	import stwu_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic      [7:0]        rdata,
	output logic                   irq,
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe
);

	typedef struct packed {
		stwu_state_e st;
		logic [3:0]  bits;
		logic [7:0]  shreg;
		logic [7:0]  own_addr;
		logic        addr_loaded;
		logic        unit_enable;
		logic        transfer_irq_enable;
		logic        tx_mode;
		logic        ack_disable;
		logic        transfer_done_flag;
		logic        start_seen_flag;
		logic        host_ack_flag;
		logic [2:0]  clr_arm;
		logic        scl_oe;
		logic        sda_oe;
		logic        irq;
		logic [7:0]  rdata;
	} stwu_core_s;

	stwu_core_s r;
	stwu_core_s next_r;

	stwu_line_if ln ();

	stwu_line_sense u_sense (
		.clk     (clk),
		.sys_rst (sys_rst),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.ln      (ln.sense)
	);

	// [R22] upper seven bits only
	function automatic logic addr_hit(input logic [7:0] rx,
		input logic [7:0] own);
		// [R9] general call
		addr_hit = (rx[7:1] == own[7:1]) || (rx[7:1] == GENERAL_CALL);
	endfunction : addr_hit

	function automatic logic [7:0] ctrl_view(input stwu_core_s s);
		ctrl_view = 8'h00;
		ctrl_view[CTRL_ENABLE_BIT] = s.unit_enable;
		ctrl_view[CTRL_IRQ_EN_BIT] = s.transfer_irq_enable;
		ctrl_view[CTRL_TX_BIT]     = s.tx_mode;
		ctrl_view[CTRL_ACK_DISABLE_BIT]  = s.ack_disable;
	endfunction : ctrl_view

	function automatic logic [7:0] status_view(input stwu_core_s s);
		status_view = 8'h00;
		status_view[STAT_DONE_BIT]  = s.transfer_done_flag;
		status_view[STAT_START_BIT] = s.start_seen_flag;
		status_view[STAT_HACK_BIT]  = s.host_ack_flag;
	endfunction : status_view

	logic data_acc;
	logic release_req;

	always_comb begin
		next_r      = r;
		data_acc    = 1'b0;
		release_req = 1'b0;
		// Read data stands for one cycle only
		next_r.rdata = 8'h00;

		// Register port
		if (wr_stb) begin
			unique case (addr)
				CTRL_IDX: begin
					next_r.unit_enable         = wdata[CTRL_ENABLE_BIT];
					next_r.transfer_irq_enable = wdata[CTRL_IRQ_EN_BIT];
					next_r.tx_mode             = wdata[CTRL_TX_BIT];
					next_r.ack_disable         = wdata[CTRL_ACK_DISABLE_BIT];
					// [R14] zero releases the clock
					release_req = !wdata[CTRL_RELEASE_BIT];
				end
				DATA_IDX: begin
					data_acc = 1'b1;
					// [R20] first write is own address
					if (!r.addr_loaded) begin
						next_r.own_addr    = wdata;
						next_r.addr_loaded = 1'b1;
					end else begin
						next_r.shreg = wdata;
					end
				end
				default: ;
			endcase
		end else if (rd_stb) begin
			unique case (addr)
				// [R15] unused control bits read zero
				CTRL_IDX: next_r.rdata = ctrl_view(r);
				STATUS_IDX: begin
					// [R19] unused status bits read zero
					next_r.rdata   = status_view(r);
					// [R2] arm clear on flags seen set
					next_r.clr_arm = {r.transfer_done_flag,
						r.start_seen_flag, r.host_ack_flag};
				end
				DATA_IDX: begin
					data_acc     = 1'b1;
					// [R21] raw shift register
					next_r.rdata = r.shreg;
				end
				default: next_r.rdata = 8'h00;
			endcase
		end

		// [R2] clear sequence; later sets below win
		if (data_acc) begin
			// [R16] [R18] clear flags armed by status read
			if (r.clr_arm[2]) next_r.transfer_done_flag = 1'b0;
			if (r.clr_arm[1]) next_r.start_seen_flag = 1'b0;
			if (r.clr_arm[0]) next_r.host_ack_flag = 1'b0;
			next_r.clr_arm = 3'h0;
		end

		// Bus side
		if (ln.stop) begin
			// [R8] back to idle
			next_r.st     = ST_IDLE;
			next_r.scl_oe = 1'b0;
			next_r.sda_oe = 1'b0;
		end else if (ln.start) begin
			// [R16] start flag
			next_r.start_seen_flag = 1'b1;
			next_r.st     = ST_ADDR;
			next_r.bits   = 4'h0;
			next_r.scl_oe = 1'b0;
			next_r.sda_oe = 1'b0;
		end else begin
			unique case (r.st)
				ST_IDLE, ST_IGNORE: ;
				ST_ADDR, ST_RX: begin
					if (ln.scl_rise && r.bits < BITS_PER_BYTE) begin
						next_r.shreg = {r.shreg[6:0], ln.sda};
						next_r.bits  = r.bits + 4'h1;
					end else if (ln.scl_fall && r.bits == BITS_PER_BYTE) begin
						if (r.st == ST_RX) begin
							// [R5] [R6] data acknowledge
							next_r.sda_oe = !r.ack_disable;
							next_r.st     = ST_RX_ACK;
						// [R24] match with interrupt enabled
						end else if (addr_hit(r.shreg, r.own_addr) &&
							r.transfer_irq_enable) begin
							// [R5] [R6] address acknowledge
							next_r.sda_oe = !r.ack_disable;
							next_r.st     = ST_ADDR_ACK;
						end else begin
							// [R25] not addressed
							next_r.start_seen_flag = 1'b0;
							next_r.st = ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (ln.scl_fall) begin
						next_r.sda_oe = 1'b0;
						// [R3] stretch after the byte
						next_r.scl_oe = 1'b1;
						// [R1] ninth clock done
						next_r.transfer_done_flag = 1'b1;
						next_r.st = ST_HOLD;
					end
				end
				ST_TX: begin
					if (ln.scl_rise) begin
						next_r.bits = r.bits + 4'h1;
					end else if (ln.scl_fall) begin
						if (r.bits == BITS_PER_BYTE) begin
							// [R13] free SDA for ninth bit
							next_r.sda_oe = 1'b0;
							next_r.st     = ST_TX_ACK;
						end else begin
							// [R12] next bit, MSB first
							next_r.shreg  = {r.shreg[6:0], 1'b0};
							next_r.sda_oe = !r.shreg[6];
						end
					end
				end
				ST_TX_ACK: begin
					if (ln.scl_rise) begin
						// [R17] host holds SDA low to acknowledge
						next_r.host_ack_flag = !ln.sda;
					end else if (ln.scl_fall) begin
						// [R13] [R3] stretch and flag
						next_r.scl_oe = 1'b1;
						next_r.transfer_done_flag = 1'b1;
						next_r.st = ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (release_req) begin
						// [R14] release held clock
						next_r.scl_oe = 1'b0;
						next_r.bits   = 4'h0;
						// [R4] direction from transmit bit
						// [R7] cleared bit leaves SDA free
						// Written value counts: one write sets and releases
						if (next_r.tx_mode) begin
							next_r.st     = ST_TX;
							next_r.sda_oe = !r.shreg[7];
						end else begin
							next_r.st     = ST_RX;
							next_r.sda_oe = 1'b0;
						end
					end
				end
				default: next_r.st = ST_IDLE;
			endcase
		end

		// [R11] disabled unit aborts and clears
		if (!next_r.unit_enable) begin
			next_r.transfer_irq_enable = 1'b0;
			next_r.tx_mode             = 1'b0;
			next_r.ack_disable         = 1'b0;
			next_r.transfer_done_flag  = 1'b0;
			next_r.start_seen_flag     = 1'b0;
			next_r.host_ack_flag       = 1'b0;
			next_r.clr_arm             = 3'h0;
			next_r.st                  = ST_IDLE;
			next_r.bits                = 4'h0;
			next_r.scl_oe              = 1'b0;
			next_r.sda_oe              = 1'b0;
		end

		// [R10] interrupt request
		next_r.irq = next_r.transfer_done_flag &&
			next_r.transfer_irq_enable;
	end

	// Shift register deliberately has no reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r.st                  <= ST_IDLE;
			r.bits                <= 4'h0;
			// [R23] own address cleared
			r.own_addr            <= OWN_ADDR_RESET;
			r.addr_loaded         <= 1'b0;
			r.unit_enable         <= 1'b0;
			r.transfer_irq_enable <= 1'b0;
			r.tx_mode             <= 1'b0;
			r.ack_disable         <= 1'b0;
			r.transfer_done_flag  <= 1'b0;
			r.start_seen_flag     <= 1'b0;
			r.host_ack_flag       <= 1'b0;
			r.clr_arm             <= 3'h0;
			r.scl_oe              <= 1'b0;
			r.sda_oe              <= 1'b0;
			r.irq                 <= 1'b0;
			r.rdata               <= 8'h00;
		end else begin
			r <= next_r;
		end
	end

	// Open-drain: only ever pulls low
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	assign rdata  = r.rdata;
	assign irq    = r.irq;
	assign scl_oe = r.scl_oe;
	assign sda_oe = r.sda_oe;

endmodule : stwu_core

// ===== rtl/stwu_pkg.sv
// Operation
// [R1] Set transfer flag after ninth clock of matched address or data byte.
// [R2] Status read then data access clears the transfer flag and interrupt.
// [R3] Hold SCL low after every byte until software releases it.
// [R4] Transmit bit set sends bytes; clear receives bytes.
// [R5] Acknowledge matched address and received data during ninth clock.
// [R6] Acknowledge disable bit suppresses acknowledge on following bytes.
// [R7] Software clears transmit bit after host no-acknowledge to free SDA.
// [R8] SDA rising while SCL high is stop; return to idle.
// [R9] All-zero address byte counts as an address match.
// [R10] Interrupt only when flag and enable both set; enable resets low.
// [R11] Clearing unit enable aborts transfer and clears control and status.
// [R12] Transmit shifts data onto SDA MSB first, one bit per SCL.
// [R13] Transmit leaves SDA free on ninth bit, then holds SCL, sets flag.
// [R14] Writing zero to clock release frees SCL; bit never sets.
// [R15] Control bits 1 to 3 read as zero.
// [R16] Start sets start flag; cleared by read sequence, disable or reset.
// [R17] Ninth transmit bit: host low sets host ack flag, high clears it.
// [R18] Host ack flag has no interrupt; cleared like the start flag.
// [R19] Status bits 0 to 4 read as zero.
// [R20] First data register write is own address; later writes load shifter.
// [R21] Data register read returns raw shift register.
// [R22] Compare bits 7:1 only; bit 0 reads received direction bit.
// [R23] Reset clears own address, leaves shift register unchanged.
// [R24] Signal and acknowledge address only on full match with interrupt enabled.
// [R25] Address mismatch clears start flag and ignores clocks until next start.
// [R26] Start is SDA falling while SCL high, sampled on the clock.
package stwu_pkg;

	localparam int        ADDR_W       = 2;
	localparam logic [1:0] CTRL_IDX    = 2'h0;
	localparam logic [1:0] STATUS_IDX  = 2'h1;
	localparam logic [1:0] DATA_IDX    = 2'h2;

	localparam int CTRL_ENABLE_BIT  = 7;
	localparam int CTRL_IRQ_EN_BIT  = 6;
	localparam int CTRL_TX_BIT      = 5;
	localparam int CTRL_ACK_DISABLE_BIT   = 4;
	localparam int CTRL_RELEASE_BIT = 0;

	localparam int STAT_DONE_BIT  = 7;
	localparam int STAT_START_BIT = 6;
	localparam int STAT_HACK_BIT  = 5;

	localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam logic [6:0] GENERAL_CALL   = 7'h00;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_HOLD,
		ST_IGNORE
	} stwu_state_e;

endpackage : stwu_pkg

// ===== rtl/stwu_line_if.sv
`timescale 1ns/1ns
interface stwu_line_if;
	logic start;
	logic stop;
	logic scl_rise;
	logic scl_fall;
	logic sda;

	modport sense (output start, output stop, output scl_rise,
		output scl_fall, output sda);
	modport core (input start, input stop, input scl_rise,
		input scl_fall, input sda);
endinterface : stwu_line_if

// ===== rtl/stwu_line_sense.sv
`timescale 1ns/1ns
module stwu_line_sense
	import stwu_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic scl_in,
	input  wire logic sda_in,
	stwu_line_if.sense ln
);

	typedef struct packed {
		logic [1:0] scl_meta;
		logic [1:0] sda_meta;
		logic       scl_q;
		logic       sda_q;
		logic       start;
		logic       stop;
		logic       rise;
		logic       fall;
	} stwu_sense_s;

	stwu_sense_s r;
	stwu_sense_s next_r;

	always_comb begin
		next_r          = r;
		// First stage feeds only the second stage
		next_r.scl_meta = {r.scl_meta[0], scl_in};
		next_r.sda_meta = {r.sda_meta[0], sda_in};
		next_r.scl_q    = r.scl_meta[1];
		next_r.sda_q    = r.sda_meta[1];
		// [R26] start detect
		next_r.start = r.scl_q && r.scl_meta[1] && r.sda_q && !r.sda_meta[1];
		// [R8] stop detect
		next_r.stop  = r.scl_q && r.scl_meta[1] && !r.sda_q && r.sda_meta[1];
		next_r.rise  = !r.scl_q && r.scl_meta[1];
		next_r.fall  = r.scl_q && !r.scl_meta[1];
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '{scl_meta: 2'h3, sda_meta: 2'h3, scl_q: 1'b1,
				sda_q: 1'b1, default: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign ln.start    = r.start;
	assign ln.stop     = r.stop;
	assign ln.scl_rise = r.rise;
	assign ln.scl_fall = r.fall;
	assign ln.sda      = r.sda_q;

endmodule : stwu_line_sense

// ===== verif/stwu_core_assertions.sv
`timescale 1ns/1ns
module stwu_core_assertions
	import stwu_pkg::*;
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0]        wdata,
	input wire logic              wr_stb,
	input wire logic              rd_stb,
	input wire logic [7:0]        rdata,
	input wire logic              irq,
	input wire logic              scl_in,
	input wire logic              scl_out,
	input wire logic              scl_oe,
	input wire logic              sda_in,
	input wire logic              sda_out,
	input wire logic              sda_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_outs_held_low: assert property (!scl_out && !sda_out)
		else $error("pin drive values not low");
	a_ctrl_unused_zero: assert property (
		$past(rd_stb) && $past(addr) == CTRL_IDX |-> rdata[3:0] == 4'h0)
		else $error("control low bits not zero");
	a_stat_unused_zero: assert property (
		$past(rd_stb) && $past(addr) == STATUS_IDX |-> rdata[4:0] == 5'h00)
		else $error("status low bits not zero");
	a_disable_clears: assert property (
		wr_stb && addr == CTRL_IDX && !wdata[CTRL_ENABLE_BIT]
		|-> ##[1:2] (!irq && !scl_oe && !sda_oe))
		else $error("disable left outputs active");
	a_release_frees: assert property (
		scl_oe && wr_stb && addr == CTRL_IDX && !wdata[CTRL_RELEASE_BIT]
		|-> ##[1:2] !scl_oe)
		else $error("clock not released");
	a_stop_goes_idle: assert property (
		scl_in && $rose(sda_in) |-> ##[2:6] (!scl_oe && !sda_oe))
		else $error("not idle after stop");
	a_sda_moves_low: assert property (
		$changed(sda_oe) |-> !scl_in)
		else $error("data line moved while clock high");
	a_stretch_in_low: assert property ($rose(scl_oe) |-> !scl_in)
		else $error("stretch began with clock high");
	a_irq_has_flag: assert property (
		$past(rd_stb && addr == STATUS_IDX && irq) |-> rdata[STAT_DONE_BIT])
		else $error("interrupt without done flag");

	cover property ($rose(irq));
	cover property ($rose(sda_oe));
	cover property ($fell(scl_oe));
endmodule : stwu_core_assertions

bind stwu_core stwu_core_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
	.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rdata(rdata), .irq(irq), .scl_in(scl_in), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// ===== verif/stwu_host_model.sv
`timescale 1ns/1ns
module stwu_host_model (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	localparam int Q = 4;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_clk
	task automatic bit_io(input logic b, output logic s);
		wait_clk(Q);
		sda_low <= !b;
		wait_clk(Q);
		scl_low <= 1'b0;
		wait_clk(1);
		while (!scl) wait_clk(1);
		wait_clk(Q);
		s = sda;
		scl_low <= 1'b1;
	endtask : bit_io
	task automatic start();
		sda_low <= 1'b0;
		scl_low <= 1'b0;
		wait_clk(1);
		while (!scl) wait_clk(1);
		wait_clk(Q);
		sda_low <= 1'b1;
		wait_clk(Q);
		scl_low <= 1'b1;
	endtask : start
	task automatic stop();
		wait_clk(Q);
		sda_low <= 1'b1;
		wait_clk(Q);
		scl_low <= 1'b0;
		wait_clk(1);
		while (!scl) wait_clk(1);
		wait_clk(Q);
		sda_low <= 1'b0;
		wait_clk(Q);
	endtask : stop
	task automatic write_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(v[i], s);
		bit_io(1'b1, s);
		ack = !s;
		wait_clk(8);
	endtask : write_byte
	task automatic read_byte(input logic give, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(!give, s);
		wait_clk(8);
	endtask : read_byte
endmodule : stwu_host_model

// ===== verif/slave_only_two_wire_serial_bench.sv
`timescale 1ns/1ns
module slave_only_two_wire_serial_bench import stwu_pkg::*;;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       wr_stb = 1'b0;
	logic       rd_stb = 1'b0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, own, d, got;
	logic       irq, scl_out, scl_oe, sda_out, sda_oe, h_scl, h_sda, ack;
	int         errors = 0;
	int         compares = 0;
	int         cycles = 0;
	// Pull-ups: a released line reads high
	wire scl = !(h_scl | scl_oe);
	wire sda = !(h_sda | sda_oe);
	always #2 clk = ~clk;

	stwu_core dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
		.scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe));
	stwu_host_model host (.clk(clk), .scl(scl), .sda(sda),
		.scl_low(h_scl), .sda_low(h_sda));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask : rd
	function automatic logic [7:0] stat(input logic dn, st, hk);
		return {dn, st, hk, 5'h00};
	endfunction : stat
	// Enable and interrupt enable always set; release bit written as zero
	function automatic logic [7:0] ctl(input logic tx, nk);
		return {2'b11, tx, nk, 4'h0};
	endfunction : ctl
	task complete_run;
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run;
		end
	end

	initial begin
		void'($urandom(32'h1e38));
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(CTRL_IDX, 8'h00);
		rd(STATUS_IDX, 8'h00);
		rd(2'h3, 8'h00);
		own = {7'($urandom_range(1, 126)), 1'b0};
		// Foreign address: never own, never general call
		d = own ^ {7'($urandom_range(1, 127)), 1'b0};
		if (d[7:1] == 7'h00) begin
			d = 8'hfe;
		end
		wr(CTRL_IDX, 8'hcf);
		rd(CTRL_IDX, ctl(1'b0, 1'b0));
		wr(DATA_IDX, own);
		host.start();
		host.write_byte(d, ack);
		chk({7'h0, ack}, 8'h00);
		rd(STATUS_IDX, 8'h00);
		host.stop();
		host.start();
		host.write_byte(own, ack);
		chk({7'h0, ack}, 8'h01);
		chk({6'h0, irq, scl_oe}, 8'h03);
		rd(STATUS_IDX, stat(1'b1, 1'b1, 1'b0));
		rd(DATA_IDX, own);
		rd(STATUS_IDX, 8'h00);
		chk({7'h0, irq}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(CTRL_IDX, ctl(1'b0, i == 3));
			d = 8'($urandom);
			host.write_byte(d, ack);
			chk({7'h0, ack}, {7'h0, i != 3});
			rd(STATUS_IDX, stat(1'b1, 1'b0, 1'b0));
			rd(DATA_IDX, d);
		end
		wr(CTRL_IDX, ctl(1'b0, 1'b0));
		host.stop();
		chk({7'h0, scl_oe}, 8'h00);
		host.start();
		host.write_byte(own | 8'h01, ack);
		rd(STATUS_IDX, stat(1'b1, 1'b1, 1'b0));
		rd(DATA_IDX, own | 8'h01);
		for (int i = 0; i < 2; i++) begin
			d = 8'($urandom);
			wr(DATA_IDX, d);
			wr(CTRL_IDX, ctl(1'b1, 1'b0));
			host.read_byte(i == 0, got);
			chk(got, d);
			rd(STATUS_IDX, stat(1'b1, 1'b0, i == 0));
			chk({6'h0, sda_oe, scl_oe}, 8'h01);
		end
		wr(CTRL_IDX, ctl(1'b0, 1'b0));
		host.stop();
		host.start();
		host.write_byte(8'h00, ack);
		chk({7'h0, ack}, 8'h01);
		rd(DATA_IDX, 8'h00);
		wr(CTRL_IDX, 8'h00);
		rd(STATUS_IDX, 8'h00);
		chk({6'h0, scl_oe, irq}, 8'h00);
		rd(CTRL_IDX, 8'h00);
		host.stop();
		// Own address but interrupt disabled: not addressed
		wr(CTRL_IDX, 8'h80);
		host.start();
		host.write_byte(own, ack);
		chk({7'h0, ack}, 8'h00);
		rd(STATUS_IDX, 8'h00);
		host.stop();
		// Mid-run reset keeps the shifter, forgets the address
		d = 8'($urandom);
		wr(DATA_IDX, d);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(DATA_IDX, d);
		rd(CTRL_IDX, 8'h00);
		wr(DATA_IDX, ~d);
		rd(DATA_IDX, d);
		complete_run;
	end
endmodule : slave_only_two_wire_serial_bench
